/* File: core/hrff_pkg.sv */
// package of constants and types for the hf reader frame formatter
package hrff_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL     = 8'h00;  // mode and enables
  localparam logic [7:0] ADDR_CMD      = 8'h04;  // direct commands
  localparam logic [7:0] ADDR_TXCNT    = 8'h08;  // payload byte count
  localparam logic [7:0] ADDR_FIFO     = 8'h0c;  // fifo push and pop
  localparam logic [7:0] ADDR_STATUS   = 8'h10;  // event flags, w1c
  localparam logic [7:0] ADDR_FSTAT    = 8'h14;  // fifo level
  localparam logic [7:0] ADDR_FDTHR    = 8'h18;  // field detect threshold

  // control fields
  localparam int CTRL_HIGHRATE   = 0;  // 1: high-rate frame, 0: 106 mode
  localparam int CTRL_RATE424    = 1;  // 1: 424, 0: 212
  localparam int CTRL_TRANS106   = 2;  // transport frame at 106
  localparam int CTRL_PRE_LO     = 3;  // preamble select low bit
  localparam int CTRL_PRE_HI     = 4;  // preamble select high bit
  localparam int CTRL_TXON       = 5;  // transmitter on

  // direct commands
  localparam logic [7:0] CMD_TX_CRC   = 8'h01;
  localparam logic [7:0] CMD_FIELD_ON = 8'h02;

  // status bits
  localparam int ST_EOT   = 0;  // end of transmit
  localparam int ST_EOR   = 1;  // end of receive
  localparam int ST_CAT   = 2;  // collision avoidance done
  localparam int ST_CAC   = 3;  // collision detected
  localparam int ST_SOFT  = 4;  // soft framing error
  localparam int ST_CRC   = 5;  // crc error
  localparam int ST_W     = 6;

  // frame constants
  localparam logic [7:0] SYNC_B0      = 8'hb2;
  localparam logic [7:0] SYNC_B1      = 8'h4d;
  localparam logic [7:0] START_VAL    = 8'hf0;
  localparam logic [15:0] CRC_INIT    = 16'h0000;
  localparam logic [15:0] CRC_POLY    = 16'h1021;
  localparam logic [7:0] PRE_BITS_48  = 8'h30;
  localparam logic [7:0] PRE_BITS_56  = 8'h38;
  localparam logic [7:0] PRE_BITS_80  = 8'h50;
  localparam logic [7:0] PRE_BITS_64  = 8'h40;
  localparam logic [7:0] PRE_BITS_RX  = 8'h10;  // zeros to accept preamble
  localparam logic [7:0] MIN_LEN      = 8'h02;
  localparam logic [7:0] FD_RESET     = 8'h20;

  // fifo
  localparam int FIFO_DEPTH = 96;
  localparam int FIFO_AW    = 7;

  // timing, 250 mhz clock
  localparam int CLK_MHZ     = 250;
  localparam int TIDT_US     = 4;     // listen time before field on
  localparam int INITIAL_GUARD_TIME_MS    = 5;     // initial guard time
  localparam int TIDT_CYC    = TIDT_US * CLK_MHZ;
  localparam int INITIAL_GUARD_TIME_CYC   = INITIAL_GUARD_TIME_MS * 1000 * CLK_MHZ;
  // bit time at 212 kb/s is about 1180 clocks, 424 about 590
  localparam int BIT212_CYC  = 1180;
  localparam int BIT424_CYC  = 590;
  localparam int BIT106_CYC  = 2360;

  // axi-lite response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // rf side bit stream
  typedef struct packed {
    logic bit_val;  // serial data bit
    logic strobe;   // one-cycle bit strobe
  } hrff_bit_type;

  typedef enum logic [1:0] {
    CA_IDLE, CA_LISTEN, CA_GUARD
  } hrff_ca_type;

endpackage

/* File: core/hrff_top.sv */
// framer, deframer, collision avoidance and axi-lite slave
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module hrff_top
  import hrff_pkg::*;
#(
  parameter int GUARD_CYC = INITIAL_GUARD_TIME_CYC  // shorten in simulation
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi-lite write address
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // rf side
  output logic             tx_bit,       // serial modulator data
  output logic             tx_on,        // transmitter enable
  input  wire logic        rx_bit,       // demodulated receive data
  input  wire logic [7:0]  ext_field     // external field level
);

  // ---------- input synchronisers ----------
  logic       rx_s1_ff, rx_s2_ff;          // receive data
  logic [7:0] fld_s1_ff, fld_s2_ff;        // field level
  always_ff @(posedge aclk) begin
    rx_s1_ff  <= rx_bit;
    rx_s2_ff  <= rx_s1_ff;
    fld_s1_ff <= ext_field;
    fld_s2_ff <= fld_s1_ff;
  end

  // crc-16 over one byte, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ---------- registers ----------
  logic [5:0]      ctrl_ff;                 // control bits
  logic [15:0]     txcnt_ff;                // payload count
  logic [7:0]      fdthr_ff;                // collision threshold
  logic [ST_W-1:0] status_ff;               // sticky flags
  logic [7:0]      fifo_mem [FIFO_DEPTH];   // shared tx/rx store
  logic [FIFO_AW-1:0] wp_ff, rp_ff;         // pointers
  logic [FIFO_AW:0]   cnt_ff;               // fill level

  // ---------- axi-lite handshakes ----------
  logic aw_ok, w_ok, ar_ok;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff;
  logic have_aw_ff, have_w_ff;
  logic wr_go;                              // both halves present
  assign aw_ok = awvalid && awready;
  assign w_ok  = wvalid && wready;
  assign ar_ok = arvalid && arready;
  assign wr_go = have_aw_ff && have_w_ff && !bvalid;

  // write address and data are taken independently, one at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
      awa_ff     <= 8'h00;
      wd_ff      <= 32'h0000_0000;
    end else begin
      if (aw_ok) begin
        awa_ff <= awaddr;
        have_aw_ff <= 1'b1;
        awready <= 1'b0;
      end
      if (w_ok) begin
        wd_ff <= wdata;
        have_w_ff <= 1'b1;
        wready <= 1'b0;
      end
      if (bvalid && bready) begin
        have_aw_ff <= 1'b0;
        have_w_ff  <= 1'b0;
        awready    <= 1'b1;
        wready     <= 1'b1;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= (awa_ff > ADDR_FDTHR || awa_ff[1:0] != 2'b00) ?
                RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic wr_ctrl, wr_cmd, wr_cnt, wr_fifo, wr_stat, wr_fd;
  assign wr_ctrl = wr_go && awa_ff == ADDR_CTRL;
  assign wr_cmd  = wr_go && awa_ff == ADDR_CMD;
  assign wr_cnt  = wr_go && awa_ff == ADDR_TXCNT;
  assign wr_fifo = wr_go && awa_ff == ADDR_FIFO;
  assign wr_stat = wr_go && awa_ff == ADDR_STATUS;
  assign wr_fd   = wr_go && awa_ff == ADDR_FDTHR;

  // ---------- frame engine state ----------
  typedef enum logic [3:0] {
    FR_IDLE, FR_PRE, FR_SYNC0, FR_SYNC1, FR_START, FR_LEN, FR_DATA,
    FR_CRC0, FR_CRC1, FR_HUNT, FR_RSYNC, FR_RLEN, FR_RDATA, FR_RCRC
  } hrff_fr_type;
  hrff_fr_type st_ff;
  logic [7:0]  sh_ff;          // byte shifter
  logic [2:0]  bit_ff;         // bit in byte
  logic [7:0]  prebits_ff;     // preamble bit counter
  logic [15:0] crc_ff;         // running crc
  logic [7:0]  left_ff;        // bytes left in payload
  logic [11:0] baud_ff;        // bit timer
  logic        bstrb;          // bit slot
  logic [11:0] bit_cyc;        // bit period per rate
  logic        highrate;       // preamble/sync framing in use
  logic        fifo_pop_tx, fifo_push_rx;
  logic        rx_first_ff;    // sync byte half seen

  // 106 transport whenever high-rate is clear, the enable bit is not read
  assign highrate = ctrl_ff[CTRL_HIGHRATE];
  assign bit_cyc = !highrate ? 12'(BIT106_CYC) :
                   ctrl_ff[CTRL_RATE424] ? 12'(BIT424_CYC) :
                   12'(BIT212_CYC);
  assign bstrb = (baud_ff == 12'h000);

  // bit timer, same rate both directions
  always_ff @(posedge aclk) begin
    if (!aresetn || st_ff == FR_IDLE || bstrb) baud_ff <= bit_cyc - 12'h001;
    else baud_ff <= baud_ff - 12'h001;
  end

  // preamble length select
  logic [7:0] pre_len;
  always_comb begin
    case ({ctrl_ff[CTRL_PRE_HI], ctrl_ff[CTRL_PRE_LO]})
      2'b00:   pre_len = PRE_BITS_48;
      2'b01:   pre_len = PRE_BITS_56;
      2'b10:   pre_len = PRE_BITS_64;
      default: pre_len = PRE_BITS_80;
    endcase
  end

  // next byte to send for each byte state
  logic [7:0] tx_byte;
  always_comb begin
    case (st_ff)
      FR_SYNC0: tx_byte = SYNC_B0;
      FR_SYNC1: tx_byte = SYNC_B1;
      FR_START: tx_byte = START_VAL;
      FR_LEN:   tx_byte = txcnt_ff[7:0] + 8'h01;
      FR_DATA:  tx_byte = fifo_mem[rp_ff];
      FR_CRC0:  tx_byte = crc_ff[15:8];
      FR_CRC1:  tx_byte = crc_ff[7:0];
      default:  tx_byte = 8'h00;
    endcase
  end

  logic tx_state;
  assign tx_state = st_ff inside {FR_SYNC0, FR_SYNC1, FR_START, FR_LEN,
                                  FR_DATA, FR_CRC0, FR_CRC1};
  logic byte_end;
  assign byte_end = bstrb && bit_ff == 3'd7;
  logic [7:0] rx_byte;
  assign rx_byte = {sh_ff[6:0], rx_s2_ff};
  assign fifo_pop_tx  = st_ff == FR_DATA && byte_end;
  // the 106 start byte is checked only, never stored
  assign fifo_push_rx = byte_end && cnt_ff != (FIFO_AW+1)'(FIFO_DEPTH) &&
                        ((st_ff == FR_RLEN && rx_first_ff) ||
                         st_ff == FR_RDATA);
  logic tx_go;
  assign tx_go = wr_cmd && wd_ff[7:0] == CMD_TX_CRC && st_ff == FR_IDLE;

  // frame sequencer: transmit then receive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= FR_IDLE;
      bit_ff <= 3'd0;
      prebits_ff <= 8'h00;
      crc_ff <= CRC_INIT;
      left_ff <= 8'h00;
      sh_ff <= 8'h00;
      rx_first_ff <= 1'b0;
    end else begin
      if (bstrb) bit_ff <= bit_ff + 3'd1;
      case (st_ff)
        FR_IDLE: begin
          bit_ff <= 3'd0;
          prebits_ff <= 8'h00;
          crc_ff <= CRC_INIT;
          left_ff <= txcnt_ff[7:0];
          if (tx_go) st_ff <= highrate ? FR_PRE : FR_START;
        end
        FR_PRE: begin  // zero bits ahead of sync
          bit_ff <= 3'd0;
          if (bstrb) prebits_ff <= prebits_ff + 8'h01;
          if (bstrb && prebits_ff == pre_len - 8'h01) st_ff <= FR_SYNC0;
        end
        FR_RSYNC, FR_HUNT, FR_RLEN, FR_RDATA, FR_RCRC: begin
          if (bstrb) sh_ff <= rx_byte;
          if (st_ff == FR_HUNT) begin
            bit_ff <= 3'd0;
            // saturate: a wrap on a long quiet line would lose a preamble
            if (bstrb)
              prebits_ff <= rx_s2_ff ? 8'h00 :
                            (prebits_ff == 8'hff) ? prebits_ff :
                            prebits_ff + 8'h01;
            if (!highrate && bstrb && rx_s2_ff) begin
              st_ff <= FR_RLEN;  // start byte begins with a one
              bit_ff <= 3'd1;
              rx_first_ff <= 1'b0;
            end else if (highrate && bstrb && rx_s2_ff &&
                         prebits_ff >= PRE_BITS_RX) begin
              st_ff <= FR_RSYNC;
              bit_ff <= 3'd1;
              rx_first_ff <= 1'b0;
            end
          end else if (byte_end) begin
            case (st_ff)
              FR_RSYNC: begin
                if (!rx_first_ff && rx_byte == SYNC_B0) rx_first_ff <= 1'b1;
                else if (rx_first_ff && rx_byte == SYNC_B1) begin
                  st_ff <= FR_RLEN;
                  rx_first_ff <= 1'b1;
                end else begin
                  st_ff <= FR_HUNT;
                  prebits_ff <= 8'h00;
                end
              end
              FR_RLEN: begin
                if (!rx_first_ff) rx_first_ff <= 1'b1;  // start byte
                else begin
                  crc_ff <= crc_byte(CRC_INIT, rx_byte);
                  left_ff <= rx_byte - 8'h01;
                  st_ff <= (rx_byte < MIN_LEN) ? FR_IDLE : FR_RDATA;
                end
              end
              FR_RDATA: begin
                crc_ff <= crc_byte(crc_ff, rx_byte);
                left_ff <= left_ff - 8'h01;
                if (left_ff == 8'h01) begin
                  st_ff <= FR_RCRC;
                  prebits_ff <= 8'h00;
                end
              end
              default: begin  // two crc bytes, checked not stored
                crc_ff <= crc_byte(crc_ff, rx_byte);
                prebits_ff <= prebits_ff + 8'h01;
                if (prebits_ff == 8'h01) st_ff <= FR_IDLE;
              end
            endcase
          end
        end
        default: begin  // byte transmit states
          if (byte_end) begin
            if (st_ff == FR_LEN || st_ff == FR_DATA)
              crc_ff <= crc_byte(crc_ff, tx_byte);
            case (st_ff)
              FR_SYNC0: st_ff <= FR_SYNC1;
              FR_SYNC1: st_ff <= FR_LEN;
              FR_START: st_ff <= FR_LEN;
              FR_LEN:   st_ff <= (left_ff == 8'h00) ? FR_CRC0 : FR_DATA;
              FR_DATA: begin
                left_ff <= left_ff - 8'h01;
                if (left_ff == 8'h01) st_ff <= FR_CRC0;
              end
              FR_CRC0:  st_ff <= FR_CRC1;
              default: begin
                st_ff <= FR_HUNT;
                prebits_ff <= 8'h00;
              end
            endcase
          end
        end
      endcase
    end
  end

  // start byte check result, bad value flags soft error
  logic soft_err, eor_ev, crc_err, eot_ev;
  assign soft_err = st_ff == FR_RLEN && byte_end && !rx_first_ff &&
                    !highrate && rx_byte != START_VAL;
  assign eot_ev = st_ff == FR_CRC1 && byte_end;
  assign eor_ev = st_ff == FR_RCRC && byte_end && prebits_ff == 8'h01;
  assign crc_err = eor_ev && crc_byte(crc_ff, rx_byte) != 16'h0000;

  // serial output, msb first
  always_ff @(posedge aclk) begin
    if (!aresetn) tx_bit <= 1'b0;
    else tx_bit <= tx_state ? tx_byte[3'd7 - bit_ff] : 1'b0;
  end

  // ---------- fifo ----------
  logic push, pop;
  logic [7:0] push_d;
  assign push = (wr_fifo && st_ff == FR_IDLE) || fifo_push_rx;
  assign push_d = fifo_push_rx ? rx_byte : wd_ff[7:0];
  assign pop = fifo_pop_tx || (ar_ok && araddr == ADDR_FIFO &&
                               cnt_ff != '0);
  always_ff @(posedge aclk) begin
    if (push && cnt_ff != (FIFO_AW+1)'(FIFO_DEPTH))
      fifo_mem[wp_ff] <= push_d;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push && cnt_ff != (FIFO_AW+1)'(FIFO_DEPTH))
        wp_ff <= (wp_ff == FIFO_AW'(FIFO_DEPTH-1)) ? '0 : wp_ff + 1'b1;
      if (pop)
        rp_ff <= (rp_ff == FIFO_AW'(FIFO_DEPTH-1)) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (FIFO_AW+1)'(push && cnt_ff !=
                (FIFO_AW+1)'(FIFO_DEPTH)) - (FIFO_AW+1)'(pop);
    end
  end

  // ---------- collision avoidance ----------
  hrff_ca_type ca_ff;
  logic [31:0] ca_cnt_ff;   // listen and guard timer
  logic ca_cat, ca_cac;
  assign ca_cac = ca_ff == CA_LISTEN && fld_s2_ff > fdthr_ff;
  assign ca_cat = ca_ff == CA_GUARD && ca_cnt_ff == 32'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ca_ff <= CA_IDLE;
      ca_cnt_ff <= 32'h0;
    end else begin
      case (ca_ff)
        CA_IDLE: if (wr_cmd && wd_ff[7:0] == CMD_FIELD_ON) begin
          ca_ff <= CA_LISTEN;
          ca_cnt_ff <= 32'(TIDT_CYC - 1);
        end
        CA_LISTEN: begin
          if (ca_cac) ca_ff <= CA_IDLE;
          else if (ca_cnt_ff == 32'h0) begin
            ca_ff <= CA_GUARD;
            ca_cnt_ff <= 32'(GUARD_CYC - 1);
          end else ca_cnt_ff <= ca_cnt_ff - 32'h1;
        end
        default: begin
          if (ca_cat) ca_ff <= CA_IDLE;
          else ca_cnt_ff <= ca_cnt_ff - 32'h1;
        end
      endcase
    end
  end

  // ---------- control and status ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= '0;
      txcnt_ff <= 16'h0000;
      fdthr_ff <= FD_RESET;
    end else begin
      if (wr_ctrl) ctrl_ff <= wd_ff[5:0];
      if (ca_ff == CA_LISTEN && !ca_cac && ca_cnt_ff == 32'h0)
        ctrl_ff[CTRL_TXON] <= 1'b1;
      if (wr_cnt) txcnt_ff <= wd_ff[15:0];
      if (wr_fd) fdthr_ff <= wd_ff[7:0];
    end
  end
  assign tx_on = ctrl_ff[CTRL_TXON];

  // sticky events, write one to clear, set wins
  logic [ST_W-1:0] ev;
  assign ev = {crc_err, soft_err, ca_cac, ca_cat, eor_ev, eot_ev};
  always_ff @(posedge aclk) begin
    if (!aresetn) status_ff <= '0;
    else status_ff <= (status_ff & ~(wr_stat ? wd_ff[ST_W-1:0] : '0)) | ev;
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (ar_ok) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      if (araddr == ADDR_CTRL) rdata <= 32'(ctrl_ff);
      else if (araddr == ADDR_TXCNT) rdata <= 32'(txcnt_ff);
      else if (araddr == ADDR_FIFO) rdata <= 32'(fifo_mem[rp_ff]);
      else if (araddr == ADDR_STATUS) rdata <= 32'(status_ff);
      else if (araddr == ADDR_FSTAT) rdata <= 32'(cnt_ff);
      else if (araddr == ADDR_FDTHR) rdata <= 32'(fdthr_ff);
      else if (araddr == ADDR_CMD) rdata <= 32'h0;
      else begin
        rdata <= 32'h0;
        rresp <= RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // hrff_top

/* File: sim/hrff_tag_model.sv */
// tag model that answers the reader at 424 kb/s
`timescale 1ns/10ps
module hrff_tag_model
  import hrff_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // reply request
  input  wire logic        go,
  input  wire logic [63:0] frame,
  // demodulated line
  output logic             rx_bit
);
  logic [63:0] sh_ff;    // bits still to send, msb first
  logic [6:0]  left_ff;  // bits left in the reply
  int          cnt_ff;   // clocks into the current bit
  logic        idle_ff;  // filler so a quiet line is never steady

  // one bit per bit period, preamble, sync, length, payload, crc
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_ff <= 7'h00;
      cnt_ff  <= 0;
      idle_ff <= 1'b0;
    end else begin
      idle_ff <= ~idle_ff;
      if (go) begin
        sh_ff   <= frame;
        left_ff <= 7'h40;
        cnt_ff  <= 0;
      end else if (left_ff != 7'h00) begin
        if (cnt_ff == BIT424_CYC - 1) begin
          cnt_ff  <= 0;
          sh_ff   <= {sh_ff[62:0], 1'b0};
          left_ff <= left_ff - 7'h01;
        end else begin
          cnt_ff <= cnt_ff + 1;
        end
      end
    end
  end

  assign rx_bit = (left_ff != 7'h00) ? sh_ff[63] : idle_ff;
endmodule // hrff_tag_model

/* File: sim/hrff_top_chk.sv */
// port checker for the hf reader frame formatter
`timescale 1ns/10ps
module hrff_top_chk
  import hrff_pkg::*;
#(
  parameter int GUARD_CYC = 20  // guard count handed on from the top
) (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // axi-lite handshakes
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // rf side
  input wire logic        tx_bit,
  input wire logic        tx_on,
  input wire logic [7:0]  ext_field
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");

  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer moved");

  property p_r_next;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_next: assert property (p_r_next) else $error("rvalid late");

  property p_ar_block;
    rvalid |-> !arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready during read");

  property p_aw_block;
    bvalid |-> !awready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("awready during write");

  // refused reads return a zero word
  property p_err_zero;
    rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error data not zero");

  // the field must be quiet for the transmitter to come on
  property p_tx_on_quiet;
    $rose(tx_on) |-> $past(ext_field, 3) <= FD_RESET;
  endproperty
  a_tx_on_quiet: assert property (p_tx_on_quiet) else $error("tx on in field");

  // a serial bit lasts hundreds of clocks at any rate
  property p_bit_len;
    $changed(tx_bit) |=> $stable(tx_bit) [*8];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("short tx bit");

  c_tx_on: cover property ($rose(tx_on));
  c_write: cover property (bvalid && bready);
  c_err: cover property (rvalid && rresp == RESP_SLVERR);
endmodule // hrff_top_chk

bind hrff_top hrff_top_chk #(.GUARD_CYC(GUARD_CYC)) u_chk (.*);

/* File: sim/test_hf_reader_frame_formatter.sv */
// testbench for the hf reader frame formatter
`timescale 1ns/10ps
module test_hf_reader_frame_formatter
  import hrff_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, ext_field;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid, go;
  logic [1:0]  bresp, rresp;
  logic [1:0]  bresp_seen;  // last write response taken
  logic        tx_bit, tx_on, rx_bit;
  logic [63:0] frame;
  int          n_fail, n_tests;

  hrff_top #(.GUARD_CYC(20)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tx_bit(tx_bit), .tx_on(tx_on), .rx_bit(rx_bit),
    .ext_field(ext_field));
  hrff_tag_model u_tag (.aclk(aclk), .aresetn(aresetn), .go(go),
    .frame(frame), .rx_bit(rx_bit));

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic tmo();
    n_fail++;
    $display("Error at %0t: wait ran out", $time);
    end_of_test();
  endtask

  // sample at the falling edge, act at the rising edge: no race
  // ready comes a cycle after valid, so every answer stalls once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta = awready; tw = wready; tb = bvalid;
      bresp_seen = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb && bready) break;
      if (tb) bready <= 1'b1;
    end
    if (n == 100) tmo();
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    logic ta, tb;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(negedge aclk);
      ta = arready; tb = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tb && rready) break;
      if (tb) rready <= 1'b1;
    end
    if (n == 100) tmo();
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
  endtask

  // poll a status flag under a bound
  task automatic poll(input int b, input int lim);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    for (n = 0; n < lim; n++) begin
      rd(ADDR_STATUS, d, r);
      if (d[b] === 1'b1) break;
    end
    if (n == lim) tmo();
  endtask

  function automatic logic [15:0] crc16(input logic [15:0] d);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rchk(ADDR_FDTHR, {24'h0, FD_RESET});
    rd(8'h1c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    wr(8'h1c, 32'h0);
    chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
  endtask

  // collision first, then a clean retry before any mode is set
  task automatic t_field();
    int n;
    @(posedge aclk);
    ext_field <= 8'hff;
    wr(ADDR_CMD, {24'h0, CMD_FIELD_ON});
    poll(ST_CAC, 600);
    @(negedge aclk);
    chk({31'h0, tx_on}, 32'h0);
    wr(ADDR_STATUS, 32'h1 << ST_CAC);
    chk({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
    rchk(ADDR_STATUS, 32'h0);
    @(posedge aclk);
    ext_field <= 8'h00;
    wr(ADDR_CMD, {24'h0, CMD_FIELD_ON});
    for (n = 0; n < 3000; n++) begin
      @(negedge aclk);
      if (tx_on === 1'b1) break;
    end
    if (n == 3000) tmo();
    rchk(ADDR_STATUS, 32'h0);
    poll(ST_CAT, 100);
  endtask

  task automatic t_tx();
    logic [47:0] v;
    int          n;
    wr(ADDR_CTRL, 32'h23);
    wr(ADDR_FIFO, 32'ha5);
    wr(ADDR_TXCNT, 32'h1);
    wr(ADDR_CMD, {24'h0, CMD_TX_CRC});
    for (n = 0; n < 40000; n++) begin
      @(negedge aclk);
      if (tx_bit === 1'b1) break;
    end
    if (n == 40000) tmo();
    chk({31'h0, n >= 48 * BIT424_CYC - 20 && n <= 48 * BIT424_CYC + 40},
        32'h1);
    repeat (BIT424_CYC / 2) @(negedge aclk);
    for (int i = 47; i >= 0; i--) begin
      v[i] = tx_bit;
      repeat (BIT424_CYC) @(negedge aclk);
    end
    chk(v[47:16], {SYNC_B0, SYNC_B1, 8'h02, 8'ha5});
    chk({16'h0, v[15:0]}, {16'h0, crc16(16'h02a5)});
    poll(ST_EOT, 300);
  endtask

  // reply arrives once transmit is done
  task automatic t_rx();
    @(posedge aclk);
    frame <= {16'h0, SYNC_B0, SYNC_B1, 8'h02, 8'h5a, crc16(16'h025a)};
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    poll(ST_EOR, 15000);
    rchk(ADDR_STATUS, (32'h1 << ST_EOT) | (32'h1 << ST_EOR) |
                      (32'h1 << ST_CAT));
    rchk(ADDR_FSTAT, 32'h2);
    rchk(ADDR_FIFO, 32'h2);
    rchk(ADDR_FIFO, 32'h5a);
  endtask

  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; ext_field = 8'h00; go = 1'b0; frame = 64'h0;
    n_fail = 0;
    n_tests = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_field();
    t_tx();
    t_rx();
    end_of_test();
  end
endmodule // test_hf_reader_frame_formatter
